/* pkg/rnq_defines.vh */
// Constants for the reset and interrupt input qualifier
`ifndef RNQ_DEFINES_VH
`define RNQ_DEFINES_VH
`define RNQ_RST_PERIODS 7'd64
`define RNQ_NMI_PERIODS 7'd24
`define RNQ_CNT_W 7
`define RNQ_CNT_RST 7'h00
`define RNQ_PORT_W 8
`define RNQ_PORT_RST 8'hff
`endif

/* design/rnq_qualifier.v */
// Reset and non-maskable interrupt input qualifier
// Functional notes
// - Chip reset after 64 high samples
// - Reset input forces port pins asynchronously
// - Reset input wakes from idle, power-down
// - Interrupt after 24 high samples
`timescale 1ns/1ps
`default_nettype none
`include "rnq_defines.vh"
module rnq_qualifier (
  // Clock and power-on reset
  input wire clk,
  input wire rst_b,
  // External control inputs
  input wire rst_pin,
  input wire nmi_pin,
  // Port values from the core
  input wire [`RNQ_PORT_W-1:0] port_core,
  // Results: qualified reset and interrupt, raw-level wake and port pins
  output reg chip_rst_r,
  output wire wake,
  output reg nmi_pulse_r,
  output wire [`RNQ_PORT_W-1:0] port_out
);

  // Reset qualifier states
  localparam [1:0] RQ_IDLE = 2'b00;
  localparam [1:0] RQ_COUNT = 2'b01;
  localparam [1:0] RQ_HELD = 2'b10;

  // Interrupt qualifier states
  localparam [1:0] NQ_IDLE = 2'b00;
  localparam [1:0] NQ_COUNT = 2'b01;
  localparam [1:0] NQ_FIRED = 2'b10;

  // Seven bits hold the longer run without wrapping
  reg [`RNQ_CNT_W-1:0] rst_cnt_r;
  reg [`RNQ_CNT_W-1:0] rst_cnt_nxt;
  reg [`RNQ_CNT_W-1:0] nmi_cnt_r;
  reg [`RNQ_CNT_W-1:0] nmi_cnt_nxt;
  reg [1:0] rst_st_r;
  reg [1:0] rst_st_nxt;
  reg [1:0] nmi_st_r;
  reg [1:0] nmi_st_nxt;
  reg chip_rst_nxt;
  reg nmi_pulse_nxt;

  // Saturating counter; a low sample clears it
  function [`RNQ_CNT_W-1:0] rnq_count;
    input lvl;
    input [`RNQ_CNT_W-1:0] cnt;
    input [`RNQ_CNT_W-1:0] lim;
    begin
      if (!lvl) begin
        rnq_count = `RNQ_CNT_RST;
      end else if (cnt < lim) begin
        rnq_count = cnt + 7'h01;
      end else begin
        rnq_count = cnt;
      end
    end
  endfunction

  // Qualification reached when the run hits its limit
  function rnq_reached;
    input [`RNQ_CNT_W-1:0] cnt;
    input [`RNQ_CNT_W-1:0] lim;
    begin
      rnq_reached = (cnt == lim);
    end
  endfunction

  // Port value seen outside: reset state wins over the core
  function [`RNQ_PORT_W-1:0] rnq_port_sel;
    input force_rst;
    input [`RNQ_PORT_W-1:0] core_val;
    begin
      if (force_rst) begin
        rnq_port_sel = `RNQ_PORT_RST;
      end else begin
        rnq_port_sel = core_val;
      end
    end
  endfunction

  // Run lengths of consecutive high samples
  // A low sample restarts the run, so glitches never add up
  always @* begin
    rst_cnt_nxt = rnq_count(rst_pin, rst_cnt_r, `RNQ_RST_PERIODS);
    nmi_cnt_nxt = rnq_count(nmi_pin, nmi_cnt_r, `RNQ_NMI_PERIODS);
  end

  // Reset qualifier: level output, held while the pin stays high
  always @* begin
    rst_st_nxt = rst_st_r;
    case (rst_st_r)
      RQ_IDLE: begin
        if (rst_pin) begin
          if (rnq_reached(rst_cnt_nxt, `RNQ_RST_PERIODS)) begin
            rst_st_nxt = RQ_HELD;
          end else begin
            rst_st_nxt = RQ_COUNT;
          end
        end
      end
      RQ_COUNT: begin
        if (!rst_pin) begin
          rst_st_nxt = RQ_IDLE;
        end else if (rnq_reached(rst_cnt_nxt, `RNQ_RST_PERIODS)) begin
          rst_st_nxt = RQ_HELD;
        end
      end
      RQ_HELD: begin
        if (!rst_pin) begin
          rst_st_nxt = RQ_IDLE;
        end
      end
      default: begin
        rst_st_nxt = RQ_IDLE;
      end
    endcase
    chip_rst_nxt = (rst_st_nxt == RQ_HELD);
  end

  // Interrupt qualifier: one pulse, then wait for a low sample
  always @* begin
    nmi_st_nxt = nmi_st_r;
    nmi_pulse_nxt = 1'b0;
    case (nmi_st_r)
      NQ_IDLE: begin
        if (nmi_pin) begin
          if (rnq_reached(nmi_cnt_nxt, `RNQ_NMI_PERIODS)) begin
            nmi_st_nxt = NQ_FIRED;
            nmi_pulse_nxt = 1'b1;
          end else begin
            nmi_st_nxt = NQ_COUNT;
          end
        end
      end
      NQ_COUNT: begin
        if (!nmi_pin) begin
          nmi_st_nxt = NQ_IDLE;
        end else if (rnq_reached(nmi_cnt_nxt, `RNQ_NMI_PERIODS)) begin
          nmi_st_nxt = NQ_FIRED;
          nmi_pulse_nxt = 1'b1;
        end
      end
      NQ_FIRED: begin
        // A long hold must not raise a second interrupt
        if (!nmi_pin) begin
          nmi_st_nxt = NQ_IDLE;
        end
      end
      default: begin
        nmi_st_nxt = NQ_IDLE;
      end
    endcase
  end

  // Pins go to reset state from the raw level, no clock needed
  // Limitation: noise on the pin still forces the port pins
  assign port_out = rnq_port_sel(rst_pin, port_core);
  // Raw level so a stopped oscillator in power-down still wakes
  assign wake = rst_pin;

  // Reset side registers
  // Asynchronous clear; the pins are sampled as synchronous
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_r <= `RNQ_CNT_RST;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_st_r <= RQ_IDLE;
    end else begin
      rst_st_r <= rst_st_nxt;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chip_rst_r <= 1'b0;
    end else begin
      chip_rst_r <= chip_rst_nxt;
    end
  end

  // Interrupt side registers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_cnt_r <= `RNQ_CNT_RST;
    end else begin
      nmi_cnt_r <= nmi_cnt_nxt;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_st_r <= NQ_IDLE;
    end else begin
      nmi_st_r <= nmi_st_nxt;
    end
  end

  // The pulse is registered so the core sees a clean strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_pulse_r <= 1'b0;
    end else begin
      nmi_pulse_r <= nmi_pulse_nxt;
    end
  end
endmodule // rnq_qualifier
`default_nettype wire

/* bench/rnq_qualifier_asserts.sv */
// Concurrent checks on the qualifier's ports
`timescale 1ns/1ps
`default_nettype none
`include "rnq_defines.vh"
module rnq_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Far-side inputs
  input wire logic rst_pin,
  input wire logic nmi_pin,
  input wire logic [7:0] port_core,
  // Design outputs
  input wire logic chip_rst_r,
  input wire logic wake,
  input wire logic nmi_pulse_r,
  input wire logic [7:0] port_out
);
  logic [6:0] rst_run_r;
  logic [6:0] nmi_run_r;

  // Runs of high samples; the interrupt run stops one past its limit
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_run_r <= 7'h00;
      nmi_run_r <= 7'h00;
    end else begin
      if (!rst_pin) begin
        rst_run_r <= 7'h00;
      end else if (rst_run_r < `RNQ_RST_PERIODS) begin
        rst_run_r <= rst_run_r + 7'h01;
      end
      if (!nmi_pin) begin
        nmi_run_r <= 7'h00;
      end else if (nmi_run_r <= `RNQ_NMI_PERIODS) begin
        nmi_run_r <= nmi_run_r + 7'h01;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence rst_release_s;
    chip_rst_r && !rst_pin;
  endsequence

  sequence nmi_rise_s;
    $rose(nmi_pulse_r);
  endsequence

  pin_force_a: assert property (
    port_out == (rst_pin ? `RNQ_PORT_RST : port_core))
    else $error("port pins not forced to reset state");
  wake_raw_a: assert property (
    wake == rst_pin)
    else $error("wake does not follow reset input");
  rst_qual_a: assert property (
    chip_rst_r == (rst_run_r == `RNQ_RST_PERIODS))
    else $error("chip reset not matching qualified run");
  rst_drop_a: assert property (
    rst_release_s |=> !chip_rst_r)
    else $error("chip reset held after low sample");
  nmi_qual_a: assert property (
    nmi_pulse_r == (nmi_run_r == `RNQ_NMI_PERIODS))
    else $error("interrupt pulse not matching qualified run");
  nmi_once_a: assert property (
    nmi_rise_s |=> !nmi_pulse_r)
    else $error("interrupt pulse longer than one cycle");
endmodule // rnq_chk

bind rnq_qualifier rnq_chk u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .rst_pin(rst_pin),
  .nmi_pin(nmi_pin),
  .port_core(port_core),
  .chip_rst_r(chip_rst_r),
  .wake(wake),
  .nmi_pulse_r(nmi_pulse_r),
  .port_out(port_out)
);
`default_nettype wire

/* bench/rnq_src.sv */
// Model of the external reset circuit and interrupt source
`timescale 1ns/1ps
`default_nettype none
module rnq_src (
  // Clock
  input wire logic clk,
  // Driven control inputs, idle low as with their pull-downs
  output logic rst_pin = 1'b0,
  output logic nmi_pin = 1'b0
);
  // Hold the levels for cnt edges, then give one low sample
  task automatic hold(input int rst_lvl, input int nmi_lvl, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      rst_pin <= rst_lvl[0];
      nmi_pin <= nmi_lvl[0];
    end
    @(posedge clk);
    rst_pin <= 1'b0;
    nmi_pin <= 1'b0;
  endtask
endmodule // rnq_src
`default_nettype wire

/* bench/rnq_qualifier_tb_top.sv */
// Testbench top for the reset and interrupt qualifier
`timescale 1ns/1ps
`default_nettype none
`include "rnq_defines.vh"
module rnq_qualifier_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rst_pin;
  logic nmi_pin;
  logic chip_rst_r;
  logic wake;
  logic nmi_pulse_r;
  logic [7:0] port_core = 8'h00;
  logic [7:0] port_out;
  logic [31:0] rnd;
  int seed = 32'hafa3094d;
  int failures = 0;
  int samples_checked = 0;
  int rst_run = 0;
  int nmi_run = 0;
  int j;

  rnq_src u_src (
    .clk(clk),
    .rst_pin(rst_pin),
    .nmi_pin(nmi_pin)
  );

  rnq_qualifier u_dut (
    .clk(clk),
    .rst_b(rst_b),
    .rst_pin(rst_pin),
    .nmi_pin(nmi_pin),
    .port_core(port_core),
    .chip_rst_r(chip_rst_r),
    .wake(wake),
    .nmi_pulse_r(nmi_pulse_r),
    .port_out(port_out)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic summarize;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    forever begin
      #4 clk = ~clk;
    end
  end

  // Random core values so the port pass-through is exercised
  always @(posedge clk) begin
    rnd = $random(seed);
    port_core <= rnd[7:0];
  end

  // Reference model: run lengths kept as plain integers
  always @(posedge clk) begin
    if (rst_b) begin
      rst_run = rst_pin ? rst_run + 1 : 0;
      nmi_run = nmi_pin ? nmi_run + 1 : 0;
      #1;
      chk(chip_rst_r, rst_run >= `RNQ_RST_PERIODS);
      chk(nmi_pulse_r, nmi_run == `RNQ_NMI_PERIODS);
      chk(port_out, rst_pin ? `RNQ_PORT_RST : port_core);
      chk(wake, rst_pin);
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (j = 20; j < 70; j++) begin
      u_src.hold((j > 40) | $random(seed), 1, j);
    end
    summarize;
  end

  // Stimulus spans about 2300 cycles; allow more than twice that
  initial begin
    #40000;
    failures++;
    summarize;
  end
endmodule // rnq_qualifier_tb_top
`default_nettype wire
